// ### rtl/bank_address_translator.sv
`timescale 1ns/100ps
`default_nettype none
`include "bank_translator_regs.svh"

module bank_address_translator (
  input  wire logic                          ref_clk_i,
  input  wire logic                          reset_n_i,
  input  wire logic [15:0]                   logical_addr_in_i,
  input  wire bank_translator_pkg::space_t   space_i,
  input  wire logic                          io_wr_i,
  input  wire logic                          io_rd_i,
  input  wire logic [7:0]                    io_wdata_i,
  output logic      [19:0]                   phys_addr_o,
  output logic      [7:0]                    io_rdata_o,
  output logic                               io_hit_o
);

  // ==========================================================
  // Reset release
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ==========================================================
  // Port decode
  logic       io_cycle;
  logic [7:0] io_port;
  logic [7:0] port_sel;
  logic [7:0] port_wr;
  logic       hit_d;

  assign io_cycle = (space_i == bank_translator_pkg::SPACE_IO);
  assign io_port  = logical_addr_in_i[7:0];

  genvar p;
  generate
    for (p = 0; p < 8; p++) begin : g_port
      // One select per translation port
      assign port_sel[p] = io_cycle && (io_port == 8'(p));

      // Write strobe lands at this edge
      assign port_wr[p] = port_sel[p] && io_wr_i;
    end
  endgenerate

  assign hit_d = |port_sel;

  // ==========================================================
  // Region boundaries and bases
  bank_translator_pkg::boundary_t  bound   [0:4];
  bank_translator_pkg::phys_base_t base    [0:4];
  logic [7:0]                      bb_word [1:4];
  logic [7:0]                      br_word [1:4];

  // Region zero has no register
  assign bound[0] = `REGION0_BOUNDARY;
  assign base[0]  = `REGION0_PHYS_BASE;

  genvar g;
  generate
    for (g = 1; g <= 4; g++) begin : g_region
      logic                           bb_wr;
      logic                           br_wr;
      bank_translator_pkg::boundary_t bound_q;
      logic [1:0]                     base_lo_q;
      logic [7:0]                     base_hi_q;

      assign bb_wr = port_wr[2 * g - 2];
      assign br_wr = port_wr[2 * g - 1];

      // Boundary, low six bits of the combined register
      always_ff @(posedge ref_clk_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
          bound_q <= `BOUNDARY_RESET;
        end else if (bb_wr) begin
          bound_q <= io_wdata_i[`BOUNDARY_MSB:`BOUNDARY_LSB];
        end
      end

      if (g == 4) begin : g_fixed
        // Fourth base ignores every write
        assign base_lo_q = `BASE_FOUR_LOW_FIXED;
        assign base_hi_q = `PHYS_BASE_FOUR_FIXED;
      end else begin : g_rw
        // Base low bits, top of the combined register
        always_ff @(posedge ref_clk_i or negedge rst_sync_q) begin
          if (!rst_sync_q) begin
            base_lo_q <= 2'(`BASE_RESET);
          end else if (bb_wr) begin
            base_lo_q <= io_wdata_i[`BASE_LOW_MSB:`BASE_LOW_LSB];
          end
        end

        // Base high bits, whole base register
        always_ff @(posedge ref_clk_i or negedge rst_sync_q) begin
          if (!rst_sync_q) begin
            base_hi_q <= 8'(`BASE_RESET >> 2);
          end else if (br_wr) begin
            base_hi_q <= io_wdata_i;
          end
        end
      end

      assign bound[g]   = bound_q;
      assign base[g]    = {base_hi_q, base_lo_q};
      assign bb_word[g] = {base_lo_q, bound_q};
      assign br_word[g] = base_hi_q;
    end
  endgenerate

  // ==========================================================
  // Region selection
  logic [4:1] above;
  logic [2:0] region;
  logic [5:0] upper;

  assign upper = logical_addr_in_i[15:10];

  generate
    for (g = 1; g <= 4; g++) begin : g_cmp
      // Region g starts one page above its boundary
      assign above[g] = (upper > bound[g]);
    end
  endgenerate

  // Highest region above its boundary wins
  always_comb begin
    region = 3'h0;
    for (int i = 1; i <= 4; i++) begin
      if (above[i]) begin
        region = 3'(i);
      end
    end
  end

  // ==========================================================
  // Physical address
  logic [9:0]  sel_base;
  logic [9:0]  page_sum;
  logic [19:0] mem_addr;

  assign sel_base = base[region];

  // Ten-bit sum wraps
  assign page_sum = sel_base + {4'h0, upper};
  assign mem_addr = {page_sum, logical_addr_in_i[9:0]};

  // Registers update at the write edge, so the next cycle sees them
  always_comb begin
    if (io_cycle) begin
      phys_addr_o = {4'h0, logical_addr_in_i};
    end else begin
      phys_addr_o = mem_addr;
    end
  end

  // ==========================================================
  // Register read-back
  logic [7:0] rdata_d;

  always_comb begin
    unique case (io_port)
      `BOUNDARY_BASE_ONE_IDX: begin
        rdata_d = bb_word[1];
      end
      `PHYS_BASE_ONE_IDX: begin
        rdata_d = br_word[1];
      end
      `BOUNDARY_BASE_TWO_IDX: begin
        rdata_d = bb_word[2];
      end
      `PHYS_BASE_TWO_IDX: begin
        rdata_d = br_word[2];
      end
      `BOUNDARY_BASE_THREE_IDX: begin
        rdata_d = bb_word[3];
      end
      `PHYS_BASE_THREE_IDX: begin
        rdata_d = br_word[3];
      end
      `BOUNDARY_BASE_FOUR_IDX: begin
        rdata_d = bb_word[4];
      end
      `PHYS_BASE_FOUR_IDX: begin
        rdata_d = br_word[4];
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
    // Memory cycles never return register data
    if (!io_cycle) begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      io_rdata_o <= 8'h00;
    end else if (io_rd_i) begin
      io_rdata_o <= rdata_d;
    end
  end

  // ==========================================================
  // Port hit
  assign io_hit_o = hit_d && (io_rd_i || io_wr_i);

endmodule

`default_nettype wire

// ### rtl/bank_translator_pkg.sv
package bank_translator_pkg;
  typedef logic [5:0] boundary_t;
  typedef logic [9:0] phys_base_t;
  typedef enum logic [0:0] {
    SPACE_MEM = 1'b0,
    SPACE_IO  = 1'b1
  } space_t;
endpackage

// ### rtl/bank_translator_regs.svh
`ifndef BANK_TRANSLATOR_REGS_SVH
`define BANK_TRANSLATOR_REGS_SVH

// I/O port indices of the translation registers
`define BOUNDARY_BASE_ONE_IDX   8'h00
`define PHYS_BASE_ONE_IDX       8'h01
`define BOUNDARY_BASE_TWO_IDX   8'h02
`define PHYS_BASE_TWO_IDX       8'h03
`define BOUNDARY_BASE_THREE_IDX 8'h04
`define PHYS_BASE_THREE_IDX     8'h05
`define BOUNDARY_BASE_FOUR_IDX  8'h06
`define PHYS_BASE_FOUR_IDX      8'h07

// Field positions in a boundary/base register
`define BASE_LOW_MSB            7
`define BASE_LOW_LSB            6
`define BOUNDARY_MSB            5
`define BOUNDARY_LSB            0

// Reset and fixed values
`define BOUNDARY_RESET          6'h3f
`define BASE_RESET              10'h000
`define REGION0_BOUNDARY        6'h00
`define REGION0_PHYS_BASE       10'h000
`define BASE_FOUR_LOW_FIXED     2'h0
`define PHYS_BASE_FOUR_FIXED    8'hf0

`endif

// ### testbench/bank_address_translator_chk.sv
`timescale 1ns/100ps
`default_nettype none
module bank_address_translator_chk (
  input wire logic                        ref_clk_i,
  input wire logic                        reset_n_i,
  input wire logic [15:0]                 logical_addr_in_i,
  input wire bank_translator_pkg::space_t space_i,
  input wire logic                        io_wr_i,
  input wire logic                        io_rd_i,
  input wire logic [19:0]                 phys_addr_o,
  input wire logic [7:0]                  io_rdata_o,
  input wire logic                        io_hit_o
);
  // ====
  // Properties
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic io = space_i == bank_translator_pkg::SPACE_IO;
  wire logic [7:0] port = logical_addr_in_i[7:0];
  a_io_passthru: assert property (io |-> phys_addr_o == {4'h0, logical_addr_in_i})
    else $error("io address altered");
  a_low_bits: assert property (!io |-> phys_addr_o[9:0] == logical_addr_in_i[9:0])
    else $error("low bits altered");
  a_region_zero: assert property (!io && logical_addr_in_i[15:10] == 6'h00
    |-> phys_addr_o == {4'h0, logical_addr_in_i}) else $error("region zero moved");
  a_base_four: assert property (io && io_rd_i && port == 8'h07 |=> io_rdata_o == 8'hf0)
    else $error("base four wrong");
  a_top_fixed: assert property (io && io_rd_i && port == 8'h06 |=> io_rdata_o[7:6] == 2'h0)
    else $error("fixed bits wrong");
  a_rdata_hold: assert property (!io_rd_i |=> $stable(io_rdata_o))
    else $error("read data moved");
  a_hit_map: assert property ((io_rd_i || io_wr_i) && io && port[7:3] == 5'h00 |-> io_hit_o)
    else $error("hit missed");
  a_hit_none: assert property (io_hit_o |-> port[7:3] == 5'h00 && (io_rd_i || io_wr_i))
    else $error("false hit");
endmodule
bind bank_address_translator bank_address_translator_chk u_chk (.*);
`default_nettype wire

// ### testbench/cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_model (
  input  wire logic                        clk_i,
  input  wire logic [7:0]                  rdata_i,
  input  wire logic                        hit_i,
  output logic      [15:0]                 addr_o,
  output var bank_translator_pkg::space_t  space_o,
  output logic                             wr_o,
  output logic                             rd_o,
  output logic      [7:0]                  wdata_o
);
  // ====
  // Bus cycles, each entered and left just after an edge
  initial begin
    addr_o = 16'h0000;
    space_o = bank_translator_pkg::SPACE_MEM;
    {wr_o, rd_o, wdata_o} = 10'h000;
  end
  task automatic access(input bank_translator_pkg::space_t s, input logic [15:0] a);
    space_o = s;
    addr_o = a;
  endtask
  task automatic io_write(input logic [7:0] p, input logic [7:0] d);
    access(bank_translator_pkg::SPACE_IO, {8'h00, p});
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    wdata_o = ~d;
    @(posedge clk_i);
    #1;
  endtask
  task automatic io_read(input logic [7:0] p, output logic [7:0] d, output logic h);
    access(bank_translator_pkg::SPACE_IO, {8'h00, p});
    rd_o = 1'b1;
    #1;
    h = hit_i;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    d = rdata_i;
    @(posedge clk_i);
    #1;
  endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic ref_clk_i, reset_n_i;
  wire logic [15:0] addr;
  wire bank_translator_pkg::space_t sp;
  wire logic wr, rd;
  wire logic [7:0] wdata, rdata;
  wire logic [19:0] phys;
  wire logic hit;
  int errors, total_checks;
  logic [5:0] bnd [5] = '{6'h00, 6'h3f, 6'h3f, 6'h3f, 6'h3f};
  logic [9:0] bas [5] = '{10'h000, 10'h000, 10'h000, 10'h000, 10'h3c0};
  logic [7:0] v [8] = '{8'h4f, 8'h20, 8'h1f, 8'h10, 8'h2f, 8'h30, 8'hf2, 8'h00};
  logic [7:0] rv;
  cpu_model u_cpu_model (.clk_i(ref_clk_i), .rdata_i(rdata), .hit_i(hit), .addr_o(addr), .space_o(sp),
    .wr_o(wr), .rd_o(rd), .wdata_o(wdata));
  bank_address_translator u_bank_address_translator (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .logical_addr_in_i(addr), .space_i(sp), .io_wr_i(wr),
    .io_rd_i(rd), .io_wdata_i(wdata), .phys_addr_o(phys), .io_rdata_o(rdata), .io_hit_o(hit));
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  // ====
  // Checks and expected map
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [19:0] model(input logic [15:0] a);
    logic [9:0] b;
    b = bas[0];
    for (int n = 1; n < 5; n++)
      if (a[15:10] > bnd[n]) b = bas[n];
    return {b + {4'h0, a[15:10]}, a[9:0]};
  endfunction
  task automatic mem(input logic [15:0] a);
    u_cpu_model.access(bank_translator_pkg::SPACE_MEM, a);
    #1;
    chk(phys, model(a));
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] p, input logic [7:0] exp);
    logic h;
    u_cpu_model.io_read(p, rv, h);
    chk({12'h000, rv}, {12'h000, exp});
    chk({19'h00000, h}, {19'h00000, p[7:3] == 5'h00});
  endtask
  // ====
  // Scenarios
  task automatic t_reset();
    rd_chk(8'h00, 8'h3f);
    rd_chk(8'h07, 8'hf0);
    mem(16'hffff);
  endtask
  task automatic t_program();
    for (int i = 0; i < 8; i++) u_cpu_model.io_write(i[7:0], v[i]);
    for (int i = 0; i < 3; i++) begin
      bnd[i+1] = v[2*i][5:0];
      bas[i+1] = {v[2*i+1], v[2*i][7:6]};
    end
    bnd[4] = v[6][5:0];
    for (int i = 0; i < 6; i++) rd_chk(i[7:0], v[i]);
    rd_chk(8'h06, 8'h32);
    rd_chk(8'h07, 8'hf0);
    rd_chk(8'h08, 8'h00);
    foreach (v[i]) mem({v[i][5:0], 10'h3ff} + 16'h0001);
  endtask
  task automatic t_update();
    u_cpu_model.io_write(8'h01, 8'h40);
    bas[1] = {8'h40, v[0][7:6]};
    mem(16'h4400);
    u_cpu_model.io_write(8'h00, 8'h20);
    bas[1] = 10'h100;
    bnd[1] = 6'h20;
    mem(16'h8400);
    u_cpu_model.access(bank_translator_pkg::SPACE_IO, 16'habcd);
    #1;
    chk(phys, 20'h0abcd);
  endtask
  task automatic complete_run();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    reset_n_i = 1'b0;
    repeat (12) @(posedge ref_clk_i);
    #1;
    reset_n_i = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1;
    t_reset();
    t_program();
    t_update();
    complete_run();
  end
endmodule
`default_nettype wire
